// File: hw/host_port_pkg.sv
// Purpose: constants for the split-strobe host port of the display companion
// Assumes: one 20 MHz clock, straps sampled at reset release
// Notes: no register bus; configuration is plain ports
package host_port_pkg;
    localparam int         STRAP_W         = 7;
    localparam int         ADDR_W          = 18;
    localparam int         DATA_W          = 16;
    localparam logic [3:0] MODE_SPLIT_BIG  = 4'hb;
    localparam int         BUS_SEL_MSB     = 2;
    localparam int         RESERVED_BIT    = 3;
    localparam int         ENDIAN_BIT      = 4;
    localparam int         HOLD_POL_BIT    = 5;
    localparam int         CLK_DIV_BIT     = 6;
    localparam logic [6:0] STRAP_RESET     = 7'h00;
    localparam int         REG_WORDS       = 16;
    localparam int         BUF_WORDS       = 64;
    localparam int         ARB_WAIT_CYCLES = 2;
    localparam logic [2:0] ARB_WAIT        = 3'(ARB_WAIT_CYCLES);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_ACK  = 4'b0100,
        ST_END  = 4'b1000
    } port_state_e;
endpackage : host_port_pkg

// File: hw/host_bus_strap_and_decode.sv
// Purpose: host port of the display companion in split-strobe 16-bit mode
// Assumes: host strobes synchronous to mclk_in; straps stable at reset release
// Notes: storage is small flop arrays standing in for registers and buffer
//        hold polarity and bus clock ratio follow the captured straps
`timescale 1ns/1ps
module host_bus_strap_and_decode
    import host_port_pkg::*;
#(
    parameter int REG_DEPTH = host_port_pkg::REG_WORDS,
    parameter int BUF_DEPTH = host_port_pkg::BUF_WORDS
) (
    // clock and reset
    input  wire logic                                mclk_in,
    input  wire logic                                rst_in,
    // configuration straps
    input  wire logic [host_port_pkg::STRAP_W-1:0]   config_straps_in,
    // host bus
    input  wire logic                                chip_select_n_in,
    input  wire logic                                mem_reg_select_in,
    input  wire logic [host_port_pkg::ADDR_W-1:0]    address_in,
    input  wire logic [host_port_pkg::DATA_W-1:0]    write_data_in,
    input  wire logic                                low_byte_write_n_in,
    input  wire logic                                high_byte_write_n_in,
    input  wire logic                                low_byte_read_n_in,
    input  wire logic                                high_byte_read_n_in,
    input  wire logic                                bus_status_input_in,
    // answer
    output logic      [host_port_pkg::DATA_W-1:0]    read_data_out,
    output logic                                     read_data_en_out,
    output logic                                     hold_out,
    // configuration status
    output logic                                     split_big_mode_out,
    output logic                                     hold_active_high_out,
    output logic                                     clock_halved_out,
    output logic                                     bus_clock_enable_out
);
    import host_port_pkg::*;

    // ======================================================
    // strap capture
    // ======================================================
    logic       capture_pending;
    logic [6:0] straps;

    // first clock after release samples the pins; async reset loads constants only
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            capture_pending <= 1'b1;
            straps          <= STRAP_RESET;
        end else if (capture_pending) begin
            capture_pending <= 1'b0;
            straps          <= config_straps_in;
        end
    end

    // ======================================================
    // strap decode
    // ======================================================
    // reserved strap is the board's duty; a wrong level is not flagged here
    logic [3:0] mode_straps;
    logic       split_mode;
    logic       hold_high;
    logic       halve_clock;
    assign mode_straps = {straps[ENDIAN_BIT], straps[BUS_SEL_MSB:0]};
    assign split_mode  = mode_straps == MODE_SPLIT_BIG;
    assign hold_high   = straps[HOLD_POL_BIT];
    assign halve_clock = straps[CLK_DIV_BIT];

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            split_big_mode_out   <= 1'b0;
            hold_active_high_out <= 1'b0;
            clock_halved_out     <= 1'b0;
        end else begin
            split_big_mode_out   <= split_mode;
            hold_active_high_out <= hold_high;
            clock_halved_out     <= halve_clock;
        end
    end

    // ======================================================
    // internal bus clock enable
    // ======================================================
    logic div_phase;
    logic bus_tick;
    // the slower rate is an enable pulse; the clock itself is never divided
    assign bus_tick = !halve_clock || div_phase;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_phase            <= 1'b0;
            bus_clock_enable_out <= 1'b0;
        end else begin
            div_phase            <= capture_pending ? 1'b0 : !div_phase;
            bus_clock_enable_out <= !capture_pending && bus_tick;
        end
    end

    // ======================================================
    // access sequencing
    // ======================================================
    // bus status is deliberately unused in this mode
    logic unused_status;
    assign unused_status = bus_status_input_in;

    logic wr_req;
    logic rd_req;
    logic req;
    assign wr_req = !low_byte_write_n_in || !high_byte_write_n_in;
    assign rd_req = !low_byte_read_n_in && !high_byte_read_n_in;
    assign req    = !chip_select_n_in && (wr_req || rd_req) && split_mode && !capture_pending;

    port_state_e state;
    logic [2:0]  wait_cnt;
    logic        done_now;
    assign done_now = (state == ST_WAIT) && (wait_cnt == 3'h0) && bus_tick;

    // wait counter runs only in the wait state and only on bus ticks
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt <= 3'h0;
        end else if (state == ST_IDLE && req) begin
            wait_cnt <= ARB_WAIT;
        end else if (state == ST_WAIT && bus_tick && wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (req) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (done_now) begin
                        state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    // a single cycle here before ST_END; hold is already released and stays released
                    state <= ST_END;
                end
                ST_END: begin
                    // wait for strobes to drop so one access gives one ack
                    if (!req) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // hold asserted until the access completes, then released until the next request
    logic next_hold_active;
    assign next_hold_active = (state == ST_IDLE && req) || (state == ST_WAIT && !done_now);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_out <= 1'b1;
        end else begin
            hold_out <= hold_high ? next_hold_active : !next_hold_active;
        end
    end

    // ======================================================
    // address decode and storage
    // ======================================================
    logic [DATA_W-1:0] reg_mem [REG_DEPTH];
    logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
    logic [ADDR_W-2:0] word_addr;
    int unsigned       reg_idx;
    int unsigned       buf_idx;
    // bits above the block are never looked at, so both blocks alias
    assign word_addr = address_in[ADDR_W-1:1];
    assign reg_idx   = word_addr % REG_DEPTH;
    // a depth that is not a power of two costs a divider here
    assign buf_idx   = word_addr % BUF_DEPTH;

    // write is taken on the completing cycle: that is when data is accepted
    logic       write_now;
    logic [1:0] lane_we;
    assign write_now = done_now && wr_req;
    assign lane_we   = {!high_byte_write_n_in, !low_byte_write_n_in};

    always_ff @(posedge mclk_in) begin
        if (write_now && !mem_reg_select_in) begin
            if (lane_we[0]) reg_mem[reg_idx][7:0]  <= write_data_in[7:0];
            if (lane_we[1]) reg_mem[reg_idx][15:8] <= write_data_in[15:8];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (write_now && mem_reg_select_in) begin
            if (lane_we[0]) buf_mem[buf_idx][7:0]  <= write_data_in[7:0];
            if (lane_we[1]) buf_mem[buf_idx][15:8] <= write_data_in[15:8];
        end
    end

    logic read_now;
    assign read_now = done_now && rd_req && !wr_req;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            read_data_out <= 16'h0000;
        end else if (read_now) begin
            read_data_out <= mem_reg_select_in ? buf_mem[buf_idx] : reg_mem[reg_idx];
        end
    end

    // flag stays up while the host keeps the read strobes and chip select
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            read_data_en_out <= 1'b0;
        end else begin
            read_data_en_out <= read_now || (read_data_en_out && rd_req && !chip_select_n_in);
        end
    end
endmodule : host_bus_strap_and_decode

// File: dv/host_port_asserts.sv
// Purpose: port timing checks for the host port
// Assumes: wait-length checks only with the undivided bus clock
// Notes: own strap copy taken at first edge after reset
`timescale 1ns/1ps
module host_port_asserts
    import host_port_pkg::*;
(
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic [6:0] config_straps_in,
    input wire logic       chip_select_n_in,
    input wire logic       low_byte_write_n_in,
    input wire logic       high_byte_write_n_in,
    input wire logic       low_byte_read_n_in,
    input wire logic       high_byte_read_n_in,
    input wire logic       hold_out,
    input wire logic       read_data_en_out,
    input wire logic       split_big_mode_out,
    input wire logic       hold_active_high_out,
    input wire logic       clock_halved_out,
    input wire logic       bus_clock_enable_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic [1:0] cnt;
    logic [6:0] cap;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) cnt <= 2'h0;
        else if (cnt != 2'h3) cnt <= cnt + 2'h1;
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) cap <= 7'h00;
        else if (cnt == 2'h0) cap <= config_straps_in;
    end
    // hold level equal to hold_active_high_out means waiting
    sequence s_take;
        $fell(chip_select_n_in) && split_big_mode_out && !clock_halved_out && cnt == 2'h3
            && (!low_byte_write_n_in || !high_byte_write_n_in
            || (!low_byte_read_n_in && !high_byte_read_n_in));
    endsequence
    sequence s_wait; (hold_out == hold_active_high_out) [*3]; endsequence
    sequence s_ack; (hold_out != hold_active_high_out) [*2]; endsequence
    property p_wait; s_take |=> s_wait; endproperty
    property p_ack; s_take |=> s_wait ##1 s_ack; endproperty
    property p_rden; s_take and !low_byte_read_n_in |-> ##4 read_data_en_out; endproperty
    property p_cfg;
        cnt == 2'h3 |-> $stable(split_big_mode_out) && $stable(hold_active_high_out)
            && $stable(clock_halved_out);
    endproperty
    property p_mode;
        cnt == 2'h3 |-> split_big_mode_out == ({cap[4], cap[2:0]} == MODE_SPLIT_BIG);
    endproperty
    property p_pol; cnt == 2'h3 |-> hold_active_high_out == cap[HOLD_POL_BIT]; endproperty
    property p_div;
        cnt == 2'h3 |-> clock_halved_out == cap[CLK_DIV_BIT] && (clock_halved_out ?
            bus_clock_enable_out != $past(bus_clock_enable_out) : bus_clock_enable_out);
    endproperty
    property p_refuse;
        cnt == 2'h3 && !split_big_mode_out |-> hold_out != hold_active_high_out;
    endproperty
    a_wait: assert property (p_wait) else $error("hold not held for wait");
    a_ack: assert property (p_ack) else $error("ack not one clean release");
    a_rden: assert property (p_rden) else $error("read data not flagged");
    a_cfg: assert property (p_cfg) else $error("strap decode moved");
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    a_pol: assert property (p_pol) else $error("hold polarity wrong");
    a_div: assert property (p_div) else $error("clock ratio wrong");
    a_refuse: assert property (p_refuse) else $error("hold in wrong mode");
endmodule : host_port_asserts
bind host_bus_strap_and_decode host_port_asserts u_host_port_asserts (.mclk_in, .rst_in,
    .config_straps_in, .chip_select_n_in, .low_byte_write_n_in, .high_byte_write_n_in,
    .low_byte_read_n_in, .high_byte_read_n_in, .hold_out, .read_data_en_out,
    .split_big_mode_out, .hold_active_high_out, .clock_halved_out, .bus_clock_enable_out);

// File: dv/host_cpu_model.sv
// Purpose: host processor side, single transfers only
// Assumes: cycle ends on the device acknowledge or after 40 clocks without one
// Notes: address and data lines are inverted after a cycle, not held
`timescale 1ns/1ps
module host_cpu_model (
    input  wire logic        mclk_in,
    input  wire logic        hold_in,
    input  wire logic        act_in,
    output logic             cs_n_out = 1'b1,
    output logic             mrs_out = 1'b0,
    output logic      [17:0] addr_out = 18'h00000,
    output logic      [15:0] wdata_out = 16'h0000,
    output logic      [1:0]  we_n_out = 2'h3,
    output logic      [1:0]  rd_n_out = 2'h3
);
    task access(input logic wr, m, input logic [17:0] a, input logic [1:0] ln,
                input logic [15:0] d, output logic ok);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        ok = 1'b0;
        @(posedge mclk_in);
        #1 cs_n_out = 1'b0;
        mrs_out = m;
        addr_out = a;
        wdata_out = d;
        if (wr) we_n_out = ~ln;
        else rd_n_out = 2'h0;
        while (n < 40 && !ok) begin
            @(posedge mclk_in);
            if (seen && hold_in !== act_in) ok = 1'b1;
            if (hold_in === act_in) seen = 1'b1;
            n++;
        end
        #1 cs_n_out = 1'b1;
        we_n_out = 2'h3;
        rd_n_out = 2'h3;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : access
endmodule : host_cpu_model

// File: dv/tb_top.sv
// Purpose: random and corner traffic through the host port
// Assumes: storage all read/write
// Notes: write/read-back pairs after re-strap to 7'h5b, one refused access after 7'h2a
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import host_port_pkg::*;
    logic mclk_in = 0, rst_in = 1, bs = 1, ok, cs_n, mrs, hold, rden, split, ah, half, bce;
    logic [6:0] straps = 7'h3b;
    logic [17:0] addr;
    logic [15:0] wdata, rdata, mem [2][64];
    logic [1:0] we_n, rd_n;
    logic [31:0] lfsr = 32'h5081;
    int errors = 0, checks = 0, cycles = 0;
    host_bus_strap_and_decode u_host_bus_strap_and_decode (.mclk_in, .rst_in,
        .config_straps_in(straps), .chip_select_n_in(cs_n), .mem_reg_select_in(mrs),
        .address_in(addr), .write_data_in(wdata), .low_byte_write_n_in(we_n[0]),
        .high_byte_write_n_in(we_n[1]), .low_byte_read_n_in(rd_n[0]),
        .high_byte_read_n_in(rd_n[1]), .bus_status_input_in(bs), .read_data_out(rdata),
        .read_data_en_out(rden), .hold_out(hold), .split_big_mode_out(split),
        .hold_active_high_out(ah), .clock_halved_out(half), .bus_clock_enable_out(bce));
    host_cpu_model u_host_cpu_model (.mclk_in, .hold_in(hold), .act_in(ah), .cs_n_out(cs_n),
        .mrs_out(mrs), .addr_out(addr), .wdata_out(wdata), .we_n_out(we_n), .rd_n_out(rd_n));
    initial forever #25 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    function int widx(input logic m, input logic [17:0] a);
        return m ? (a >> 1) % BUF_WORDS : (a >> 1) % REG_WORDS;
    endfunction : widx
    function logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task complete_run;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task do_reset(input logic [6:0] s);
        straps = s;
        rst_in = 1;
        repeat (5) @(posedge mclk_in);
        #1 rst_in = 0;
        repeat (4) @(posedge mclk_in);
        #1;
    endtask : do_reset
    task op(input logic wr, m, input logic [17:0] a, input logic [1:0] ln);
        int i;
        lfsr = lfsr_next(lfsr);
        bs = lfsr[20];
        i = widx(m, a);
        u_host_cpu_model.access(wr, m, a, ln, lfsr[15:0], ok);
        `CHK(ok, 1'b1)
        if (wr && ln[0]) mem[m][i][7:0] = lfsr[7:0];
        if (wr && ln[1]) mem[m][i][15:8] = lfsr[15:8];
        if (!wr) `CHK(rdata, mem[m][i])
    endtask : op
    initial begin
        do_reset(7'h3b);
        `CHK({split, ah, half}, 3'b110)
        straps = 7'h00;
        repeat (3) @(posedge mclk_in);
        #1;
        `CHK({split, ah, half}, 3'b110)
        for (int i = 0; i < REG_WORDS + BUF_WORDS; i++) op(1, i >= REG_WORDS, 18'(2 * i), 2'h3);
        op(1, 0, 18'h3fffe, 2'h2);
        op(0, 0, 18'h0001e, 2'h0);
        repeat (150) op(lfsr[0], lfsr[1], lfsr[23:6], lfsr[3:2] == 0 ? 2'h1 : lfsr[3:2]);
        do_reset(7'h5b);
        `CHK({split, ah, half}, 3'b101)
        repeat (8) begin
            op(1, lfsr[1], lfsr[23:6], 2'h3);
            op(0, mrs, ~addr, 2'h0);
        end
        do_reset(7'h2a);
        `CHK(split, 1'b0)
        u_host_cpu_model.access(1, 0, 18'h00000, 2'h3, 16'h0000, ok);
        `CHK(ok, 1'b0)
        complete_run();
    end
endmodule : tb_top
